// ---- asw_regs.svh ----
// Register offsets, field positions and timing constants of the core datapath
`ifndef ASW_REGS_SVH
`define ASW_REGS_SVH
`define ASW_ADR_INDIRECT 6'h00
`define ASW_ADR_POINTER 6'h01
`define ASW_ADR_WORKING 6'h05
`define ASW_ADR_FLAGS 6'h0A
`define ASW_PTR_FILL 2'h3
`define ASW_BIT_C 0
`define ASW_BIT_AC 1
`define ASW_BIT_Z 2
`define ASW_BIT_OV 3
`define ASW_BIT_PDF 4
`define ASW_BIT_TO 5
`define ASW_SW_FLAG_MASK 8'h0F
`define ASW_QTR_LAST 2'h3
`define ASW_WDT_BASE 8
`define ASW_WDT_W 12
`endif

// ---- asw_pkg.sv ----
// Types shared by the core datapath
package asw_pkg;
	typedef enum logic [4:0] {
		ALU_ADD = 5'h00, ALU_ADC = 5'h01, ALU_SUB = 5'h02, ALU_SBC = 5'h03, ALU_DAA = 5'h04,
		ALU_AND = 5'h05, ALU_OR = 5'h06, ALU_XOR = 5'h07, ALU_CPL = 5'h08,
		ALU_RL = 5'h09, ALU_RR = 5'h0A, ALU_RLC = 5'h0B, ALU_RRC = 5'h0C,
		ALU_INC = 5'h0D, ALU_DEC = 5'h0E, ALU_PASS = 5'h0F
	} asw_op_e;
	typedef enum logic [2:0] {
		KICK_IDLE = 3'b001,
		KICK_GOT1 = 3'b010,
		KICK_GOT2 = 3'b100
	} asw_kick_e;
	typedef struct packed {
		logic [5:0] ptr;
		logic [7:0] acc;
		logic [7:0] flags;
		logic [1:0] qtr;
		logic [11:0] wdt;
		asw_kick_e kick;
		logic halted;
		logic clk_qtr;
		logic chip_rst;
		logic wake;
		logic [7:0] rdata;
		logic skip;
		logic [5:0] mem_addr;
		logic [7:0] mem_wdata;
		logic mem_we;
	} asw_state_s;
endpackage : asw_pkg

// ---- asw_core.sv ----
// Core datapath: indirect access, working register, ALU, flags and watchdog
//
// How it works
// (RQ1) Location 0x00 accesses memory at pointer
// (RQ2) Pointer at 0x00: read zero, write nothing
// (RQ3) Pointer holds six bits, top reads ones
// (RQ4) Working register at 0x05, immediates, moves
// (RQ5) ALU does arithmetic, logic, rotate, skip tests
// (RQ6) ALU operations update affected arithmetic flags
// (RQ7) Flags at 0x0A; writes spare watchdog flags
// (RQ8) Bit 0 carry, no-borrow, rotate-through-carry
// (RQ9) Bit 1 nibble carry or no nibble borrow
// (RQ10) Bit 2 set on zero result
// (RQ11) Bit 3 set on signed overflow
// (RQ12) Bit 4 cleared by kick, set by sleep
// (RQ13) Bit 5 cleared by kick/sleep, set timeout
// (RQ14) Flag bits 6 and 7 read zero
// (RQ15) Calls do not save flags
// (RQ16) Watchdog counts instruction clock, 2^n, n=8..11
// (RQ17) Disabled watchdog: kicks no-op, no timeout
// (RQ18) Overflow in run resets chip, sets flag
// (RQ19) Prescaler cleared by pin, kick, sleep
// (RQ20) Single or dual kick mode by option
// (RQ21) Sleep stops all clocked logic
// (RQ22) RC mode drives clock/4 on pin
// (RQ23) Timeout in sleep wakes, resets counter only; here the dog is frozen while halted, so no timeout comes in sleep
// (RQ24) Decoder strobes; flags update with writeback
`timescale 1ns/100ps
`include "asw_regs.svh"

module asw_core
	import asw_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ext_clear_pin_n_i,
	input wire logic opt_wdt_en_i,
	input wire logic [1:0] opt_wdt_sel_i,
	input wire logic opt_dual_kick_i,
	input wire logic opt_rc_osc_i,
	input wire logic exec_i,
	input wire logic [5:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	input wire logic use_imm_i,
	input wire logic [7:0] imm_i,
	input wire logic alu_en_i,
	input wire asw_op_e alu_op_i,
	input wire logic alu_to_acc_i,
	input wire logic skip_zero_i,
	input wire logic skip_nonzero_i,
	input wire logic kick_single_i,
	input wire logic kick_first_half_i,
	input wire logic kick_second_half_i,
	input wire logic sleep_i,
	input wire logic wake_event_i,
	input wire logic [7:0] mem_rdata_i,
	output logic [7:0] rdata_o,
	output logic [7:0] acc_o,
	output logic [7:0] flags_o,
	output logic skip_o,
	output logic [5:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	output logic mem_we_o,
	output logic chip_rst_o,
	output logic wake_o,
	output logic halted_o,
	output logic clk_qtr_o
);

	// ************************************************************
	// State
	// ************************************************************
	asw_state_s s_q;
	asw_state_s s_d;

	logic [5:0] eff_addr;
	logic ind_nil;
	logic [7:0] rd_val;
	logic [7:0] opa;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] res;
	logic c_new;
	logic ac_new;
	logic ov_new;
	logic arith;
	logic c7;
	logic [11:0] wdt_lim;
	logic tick;
	logic kick_ok;
	logic timeout;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s_d = s_q;
		s_d.chip_rst = 1'b0;
		s_d.wake = 1'b0;
		s_d.mem_we = 1'b0;
		// Indirect access through the pointer [RQ1]
		eff_addr = (addr_i == `ASW_ADR_INDIRECT) ? s_q.ptr : addr_i;
		ind_nil = (addr_i == `ASW_ADR_INDIRECT) && (s_q.ptr == `ASW_ADR_INDIRECT); // [RQ2]
		// Read mux; the pointer reads with its top two bits high [RQ3]
		if (ind_nil) begin
			rd_val = 8'h00; // [RQ2]
		end else if (eff_addr == `ASW_ADR_POINTER) begin
			rd_val = {`ASW_PTR_FILL, s_q.ptr}; // [RQ3]
		end else if (eff_addr == `ASW_ADR_WORKING) begin
			rd_val = s_q.acc; // [RQ4]
		end else if (eff_addr == `ASW_ADR_FLAGS) begin
			rd_val = {2'h0, s_q.flags[5:0]}; // [RQ14]
		end else begin
			rd_val = mem_rdata_i;
		end
		// Second operand is the addressed location from the read mux unless immediate [RQ4]
		opa = use_imm_i ? imm_i : rd_val;
		// ALU [RQ5]
		sum = 9'h000;
		nib = 5'h00;
		res = 8'h00;
		c_new = s_q.flags[`ASW_BIT_C];
		ac_new = s_q.flags[`ASW_BIT_AC];
		ov_new = s_q.flags[`ASW_BIT_OV];
		arith = 1'b0;
		c7 = 1'b0;
		case (alu_op_i)
			ALU_ADD, ALU_ADC: begin
				sum = {1'b0, s_q.acc} + {1'b0, opa} + {8'h00, (alu_op_i == ALU_ADC) & s_q.flags[`ASW_BIT_C]};
				nib = {1'b0, s_q.acc[3:0]} + {1'b0, opa[3:0]} + {4'h0, (alu_op_i == ALU_ADC) & s_q.flags[`ASW_BIT_C]};
				c7 = s_q.acc[7] ^ opa[7] ^ sum[7];
				arith = 1'b1;
			end
			ALU_SUB, ALU_SBC: begin
				// Subtract as add of complement; carry means no borrow [RQ8]
				sum = {1'b0, opa} + {1'b0, ~s_q.acc} + {8'h00, (alu_op_i == ALU_SUB) | s_q.flags[`ASW_BIT_C]};
				nib = {1'b0, opa[3:0]} + {1'b0, ~s_q.acc[3:0]} + {4'h0, (alu_op_i == ALU_SUB) | s_q.flags[`ASW_BIT_C]};
				c7 = opa[7] ^ ~s_q.acc[7] ^ sum[7];
				arith = 1'b1;
			end
			ALU_INC: begin
				res = opa + 8'h01;
			end
			ALU_DEC: begin
				res = opa - 8'h01;
			end
			ALU_DAA: begin
				// Decimal adjust can only set carry here; zero still follows the result as for every op
				sum = {1'b0, s_q.acc};
				if (s_q.acc[3:0] > 4'h9 || s_q.flags[`ASW_BIT_AC]) begin
					sum = sum + 9'h006;
				end
				if (sum[7:4] > 4'h9 || s_q.flags[`ASW_BIT_C] || sum[8]) begin
					sum = sum + 9'h060;
				end
				res = sum[7:0];
				c_new = sum[8] | s_q.flags[`ASW_BIT_C];
			end
			ALU_AND: res = s_q.acc & opa;
			ALU_OR: res = s_q.acc | opa;
			ALU_XOR: res = s_q.acc ^ opa;
			ALU_CPL: res = ~opa;
			ALU_RL: res = {opa[6:0], opa[7]};
			ALU_RR: res = {opa[0], opa[7:1]};
			ALU_RLC: begin
				res = {opa[6:0], s_q.flags[`ASW_BIT_C]};
				c_new = opa[7]; // [RQ8]
			end
			ALU_RRC: begin
				res = {s_q.flags[`ASW_BIT_C], opa[7:1]};
				c_new = opa[0]; // [RQ8]
			end
			default: res = opa;
		endcase
		if (arith) begin
			res = sum[7:0];
			c_new = sum[8]; // [RQ8]
			ac_new = nib[4]; // [RQ9]
			ov_new = c7 ^ sum[8]; // [RQ11]
		end
		// Kick qualification by mode; disabled dog ignores all [RQ17] [RQ20]
		kick_ok = opt_wdt_en_i && (opt_dual_kick_i ?
			((kick_second_half_i && s_q.kick == KICK_GOT1) || (kick_first_half_i && s_q.kick == KICK_GOT2)) :
			kick_single_i);
		// Last count before overflow is 2^n - 1 instruction ticks
		wdt_lim = 12'hFFF >> (`ASW_WDT_W - `ASW_WDT_BASE - {2'h0, opt_wdt_sel_i}); // [RQ16]
		tick = (s_q.qtr == `ASW_QTR_LAST);
		timeout = opt_wdt_en_i && tick && (s_q.wdt == wdt_lim); // [RQ18]
		// Quarter-rate divider for instruction clock and pin [RQ22]
		if (!s_q.halted) begin
			s_d.qtr = s_q.qtr + 2'h1;
			s_d.clk_qtr = opt_rc_osc_i & s_q.qtr[1]; // [RQ22]
		end
		if (s_q.halted) begin
			// Oscillator stopped: only a wake event or the clear pin acts [RQ21]
			// Wake keeps every register; only the halt ends [RQ23]
			if (wake_event_i) begin
				s_d.halted = 1'b0;
				s_d.wake = 1'b1;
			end
		end else if (exec_i) begin
			// One instruction per strobe; results and flags together [RQ24]
			if (rd_i) begin
				s_d.rdata = rd_val; // [RQ1]
			end
			s_d.skip = (skip_zero_i && res == 8'h00) || (skip_nonzero_i && res != 8'h00); // [RQ5]
			if (alu_en_i) begin
				s_d.flags[`ASW_BIT_Z] = (res == 8'h00); // [RQ10]
				if (alu_op_i != ALU_INC && alu_op_i != ALU_DEC && alu_op_i < ALU_AND || alu_op_i > ALU_RR) begin
					s_d.flags[`ASW_BIT_C] = c_new; // [RQ6]
				end
				s_d.flags[`ASW_BIT_AC] = ac_new; // [RQ9]
				s_d.flags[`ASW_BIT_OV] = ov_new; // [RQ11]
				if (alu_to_acc_i) begin
					s_d.acc = res; // [RQ4]
				end
			end
			if (wr_i && !ind_nil) begin
				// Writes go to registers or memory; flags keep 4 and 5 [RQ7]
				if (eff_addr == `ASW_ADR_POINTER) begin
					s_d.ptr = wdata_i[5:0]; // [RQ3]
				end else if (eff_addr == `ASW_ADR_WORKING) begin
					s_d.acc = wdata_i; // [RQ4]
				end else if (eff_addr == `ASW_ADR_FLAGS) begin
					s_d.flags = (s_q.flags & ~`ASW_SW_FLAG_MASK) | (wdata_i & `ASW_SW_FLAG_MASK); // [RQ7]
				end else begin
					s_d.mem_addr = eff_addr; // [RQ1]
					s_d.mem_wdata = wdata_i;
					s_d.mem_we = 1'b1;
				end
			end
			// Dual kick pairing state [RQ20]
			if (opt_dual_kick_i && opt_wdt_en_i) begin
				// Remember which half came first; only the other half completes the pair
				if (kick_ok) begin
					s_d.kick = KICK_IDLE;
				end else if (kick_first_half_i) begin
					s_d.kick = KICK_GOT1;
				end else if (kick_second_half_i) begin
					s_d.kick = KICK_GOT2;
				end
			end
			if (kick_ok) begin
				s_d.flags[`ASW_BIT_PDF] = 1'b0; // [RQ12]
				s_d.flags[`ASW_BIT_TO] = 1'b0; // [RQ13]
			end
			if (sleep_i && opt_wdt_en_i) begin
				s_d.flags[`ASW_BIT_PDF] = 1'b1; // [RQ12]
				s_d.flags[`ASW_BIT_TO] = 1'b0; // [RQ13]
				s_d.halted = 1'b1; // [RQ21]
			end else if (sleep_i) begin
				s_d.flags[`ASW_BIT_PDF] = 1'b1;
				s_d.flags[`ASW_BIT_TO] = 1'b0;
				s_d.halted = 1'b1;
			end
		end
		// Watchdog count; halted dog frozen, cleared by kick or sleep [RQ19]
		if (!s_q.halted) begin
			if (exec_i && (kick_ok || sleep_i)) begin
				s_d.wdt = 12'h000; // [RQ19]
			end else if (timeout) begin
				s_d.wdt = 12'h000;
				s_d.flags[`ASW_BIT_TO] = 1'b1; // [RQ13]
				s_d.chip_rst = 1'b1; // [RQ18]
			end else if (tick && opt_wdt_en_i) begin
				s_d.wdt = s_q.wdt + 12'h001; // [RQ16]
			end
		end
		// Low pin clears prescaler and kick pairing [RQ19]
		if (!ext_clear_pin_n_i) begin
			s_d.wdt = 12'h000;
			s_d.kick = KICK_IDLE;
			s_d.chip_rst = 1'b1;
			s_d.halted = 1'b0;
		end
	end

	// ************************************************************
	// Register stage; reset is power-up, clears the watchdog flags
	// ************************************************************
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '{ptr: 6'h00, acc: 8'h00, flags: 8'h00, qtr: 2'h0, wdt: 12'h000, kick: KICK_IDLE,
				halted: 1'b0, clk_qtr: 1'b0, chip_rst: 1'b0, wake: 1'b0, rdata: 8'h00, skip: 1'b0,
				mem_addr: 6'h00, mem_wdata: 8'h00, mem_we: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops; flags never pushed on a call [RQ15]
	assign rdata_o = s_q.rdata;
	assign acc_o = s_q.acc;
	assign flags_o = s_q.flags;
	assign skip_o = s_q.skip;
	assign mem_addr_o = s_q.mem_addr;
	assign mem_wdata_o = s_q.mem_wdata;
	assign mem_we_o = s_q.mem_we;
	assign chip_rst_o = s_q.chip_rst;
	assign wake_o = s_q.wake;
	assign halted_o = s_q.halted;
	assign clk_qtr_o = s_q.clk_qtr;

	// ************************************************************
	// Checks
	// ************************************************************
	a_ptr_top_ones: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ3]
		exec_i && rd_i && !s_q.halted && addr_i == `ASW_ADR_POINTER |=> rdata_o[7:6] == `ASW_PTR_FILL)
		else $error("pointer top bits not ones");
	a_nil_read_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ2]
		exec_i && rd_i && !s_q.halted && ind_nil |=> rdata_o == 8'h00)
		else $error("indirect self read not zero");
	a_nil_write_none: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ2]
		exec_i && !s_q.halted && ind_nil |=> !mem_we_o)
		else $error("indirect self write reached memory");
	a_ind_write_route: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ1]
		exec_i && wr_i && !s_q.halted && ext_clear_pin_n_i && addr_i == `ASW_ADR_INDIRECT && s_q.ptr > `ASW_ADR_FLAGS
		|=> mem_we_o && mem_addr_o == $past(s_q.ptr))
		else $error("indirect write misrouted");
	a_flag_write_keep: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ7]
		exec_i && wr_i && !s_q.halted && addr_i == `ASW_ADR_FLAGS && !kick_ok && !sleep_i && !timeout
		&& ext_clear_pin_n_i |=> flags_o[5:4] == $past(flags_o[5:4]))
		else $error("flag write touched watchdog flags");
	a_flag_high_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ14]
		flags_o[7:6] == 2'h0)
		else $error("flag bits 6-7 not zero");
	a_sleep_flags: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ12]
		exec_i && sleep_i && !s_q.halted && ext_clear_pin_n_i |=> halted_o && flags_o[5:4] == 2'b01)
		else $error("sleep flags wrong");
	a_timeout_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ18]
		timeout && !s_q.halted && !(exec_i && (kick_ok || sleep_i)) && ext_clear_pin_n_i
		|=> chip_rst_o && flags_o[5])
		else $error("timeout did not reset");
	a_dog_off_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ17]
		!opt_wdt_en_i && ext_clear_pin_n_i |=> !chip_rst_o)
		else $error("disabled dog reset the chip");
	a_halt_frozen: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ21]
		s_q.halted && ext_clear_pin_n_i |=> $stable(s_q.wdt) && $stable(acc_o))
		else $error("logic ran while halted");
	a_add_carry: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ8]
		exec_i && alu_en_i && !s_q.halted && alu_op_i == ALU_ADD && !wr_i
		|=> {flags_o[0], 8'h00} == (({1'b0, $past(acc_o)} + {1'b0, $past(opa)}) & 9'h100)
		&& flags_o[2] == (8'($past(acc_o) + $past(opa)) == 8'h00))
		else $error("add flags wrong");
	a_sub_carry: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ8]
		exec_i && alu_en_i && !s_q.halted && alu_op_i == ALU_SUB && !wr_i
		|=> {flags_o[0], 8'h00} == (({1'b0, $past(opa)} + {1'b0, ~$past(acc_o)} + 9'h001) & 9'h100))
		else $error("subtract carry wrong");
	a_add_wrap: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ11]
		exec_i && alu_en_i && !s_q.halted && alu_op_i == ALU_ADD && !wr_i
		|=> flags_o[3] == (($past(acc_o[7]) == $past(opa[7]))
		&& ((8'($past(acc_o) + $past(opa)) >= 8'h80) != $past(acc_o[7]))))
		else $error("add overflow flag wrong");
	a_kick_clears: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ13]
		exec_i && !s_q.halted && opt_wdt_en_i && !opt_dual_kick_i && kick_single_i && !sleep_i
		|=> flags_o[5:4] == 2'b00)
		else $error("kick left watchdog flags set");
	a_lone_half: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ20]
		exec_i && !s_q.halted && opt_wdt_en_i && opt_dual_kick_i && kick_first_half_i && !kick_second_half_i
		&& s_q.kick != KICK_GOT2 && !sleep_i && !timeout && ext_clear_pin_n_i && s_q.wdt != 12'h000
		|=> s_q.wdt != 12'h000 && flags_o[5:4] == $past(flags_o[5:4]))
		else $error("lone half kick cleared the dog");
	a_pin_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ19]
		!ext_clear_pin_n_i |=> chip_rst_o && !halted_o && s_q.wdt == 12'h000)
		else $error("clear pin did not clear the dog");
	a_qtr_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RQ22]
		!opt_rc_osc_i && !s_q.halted |=> !clk_qtr_o)
		else $error("quarter clock on pin outside RC mode");
	c_sleep: cover property (@(posedge mclk_i) disable iff (!rst_n_i) exec_i && sleep_i ##1 halted_o);
	c_wake: cover property (@(posedge mclk_i) disable iff (!rst_n_i) halted_o ##1 wake_o);
	c_timeout: cover property (@(posedge mclk_i) disable iff (!rst_n_i) chip_rst_o && flags_o[5]);
	c_indirect: cover property (@(posedge mclk_i) disable iff (!rst_n_i) exec_i && wr_i && addr_i == 6'h00);
	c_dual_kick: cover property (@(posedge mclk_i) disable iff (!rst_n_i) opt_dual_kick_i && kick_ok);

endmodule : asw_core

// ---- asw_mem_model.sv ----
// Data memory partner model that sits behind the core's memory port
`timescale 1ns/100ps

module asw_mem_model (
	input wire logic mclk_i,
	input wire logic [5:0] mem_addr_i,
	input wire logic [7:0] mem_wdata_i,
	input wire logic mem_we_i,
	input wire logic [5:0] rd_addr_i,
	output logic [7:0] mem_rdata_o
);
	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] mem [64];
	int writes = 0;

	// Distinct fill so that a stale or missed read cannot look right
	initial begin
		for (int i = 0; i < 64; i++) begin
			mem[i] = 8'hA0 ^ 8'(i);
		end
	end

	// One registered strobe stores one byte at the redirected address
	always @(posedge mclk_i) begin
		if (mem_we_i === 1'b1) begin
			mem[mem_addr_i] <= mem_wdata_i;
			writes <= writes + 1;
		end
	end

	// Decoder presents the effective address, data returns at once
	assign mem_rdata_o = mem[rd_addr_i];
endmodule : asw_mem_model

// ---- testbench.sv ----
// Self-checking bench for the core datapath with its data memory model
`timescale 1ns/100ps
`include "asw_regs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end

module testbench import asw_pkg::*; ;
	typedef struct {asw_op_e op; logic [7:0] acc, imm, res; logic cin; logic [3:0] fl, mk;} asw_row_s;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ext_clear_pin_n_i = 1'b1, opt_wdt_en_i = 1'b0, opt_dual_kick_i = 1'b0, opt_rc_osc_i = 1'b1;
	logic [1:0] opt_wdt_sel_i = 2'h0;
	logic exec_i, rd_i, wr_i, use_imm_i, alu_en_i, alu_to_acc_i, skip_zero_i, skip_nonzero_i;
	logic kick_single_i, kick_first_half_i, kick_second_half_i, sleep_i, wake_event_i;
	logic [5:0] addr_i, rd_ptr, mem_addr_o;
	logic [7:0] wdata_i, imm_i, mem_rdata_i, rdata_o, acc_o, flags_o, mem_wdata_o;
	asw_op_e alu_op_i;
	logic skip_o, mem_we_o, chip_rst_o, wake_o, halted_o, clk_qtr_o, q;
	int num_errors = 0, checked = 0, n, wn;
	// Mask keeps only the flags each operation is known to define
	asw_row_s rows [17] = '{
		'{ALU_ADD, 8'h80, 8'h80, 8'h00, 1'b0, 4'hD, 4'hF}, '{ALU_ADD, 8'h0F, 8'h01, 8'h10, 1'b0, 4'h2, 4'hF},
		'{ALU_ADC, 8'h7F, 8'h00, 8'h80, 1'b1, 4'hA, 4'hF}, '{ALU_SUB, 8'h01, 8'h00, 8'hFF, 1'b0, 4'h0, 4'hF},
		'{ALU_SUB, 8'h05, 8'h05, 8'h00, 1'b0, 4'h7, 4'hF}, '{ALU_SBC, 8'h01, 8'h80, 8'h7E, 1'b0, 4'h9, 4'hF},
		'{ALU_DAA, 8'h0A, 8'h0A, 8'h10, 1'b0, 4'h0, 4'h0}, '{ALU_AND, 8'hF0, 8'h0F, 8'h00, 1'b0, 4'h4, 4'h4},
		'{ALU_OR, 8'hF0, 8'h0F, 8'hFF, 1'b0, 4'h0, 4'h4}, '{ALU_XOR, 8'h5A, 8'h5A, 8'h00, 1'b0, 4'h4, 4'h4},
		'{ALU_CPL, 8'h5A, 8'h5A, 8'hA5, 1'b0, 4'h0, 4'h4}, '{ALU_RL, 8'h81, 8'h81, 8'h03, 1'b0, 4'h0, 4'h0},
		'{ALU_RR, 8'h81, 8'h81, 8'hC0, 1'b0, 4'h0, 4'h0}, '{ALU_RLC, 8'h81, 8'h81, 8'h02, 1'b0, 4'h1, 4'h1},
		'{ALU_RRC, 8'h01, 8'h01, 8'h80, 1'b1, 4'h1, 4'h1}, '{ALU_INC, 8'hFF, 8'hFF, 8'h00, 1'b0, 4'h4, 4'h4},
		'{ALU_DEC, 8'h01, 8'h01, 8'h00, 1'b0, 4'h4, 4'h4}};

	asw_core dut (.mclk_i, .rst_n_i, .ext_clear_pin_n_i, .opt_wdt_en_i, .opt_wdt_sel_i, .opt_dual_kick_i,
		.opt_rc_osc_i, .exec_i, .addr_i, .rd_i, .wr_i, .wdata_i, .use_imm_i, .imm_i, .alu_en_i, .alu_op_i,
		.alu_to_acc_i, .skip_zero_i, .skip_nonzero_i, .kick_single_i, .kick_first_half_i, .kick_second_half_i,
		.sleep_i, .wake_event_i, .mem_rdata_i, .rdata_o, .acc_o, .flags_o, .skip_o, .mem_addr_o, .mem_wdata_o,
		.mem_we_o, .chip_rst_o, .wake_o, .halted_o, .clk_qtr_o);
	asw_mem_model u_mem (.mclk_i(mclk_i), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
		.mem_we_i(mem_we_o), .rd_addr_i(rd_ptr), .mem_rdata_o(mem_rdata_i));

	// 20 MHz system clock
	initial begin
		forever #25 mclk_i = ~mclk_i;
	end

	// ****************************************
	// Tasks
	// ****************************************
	// One instruction strobe; outputs are settled at the following falling edge
	task automatic run(input logic w, r, input logic [5:0] a, input logic [7:0] d, input logic al,
		input asw_op_e op, input logic [5:0] ev);
		@(negedge mclk_i);
		{wr_i, rd_i, use_imm_i, alu_en_i, alu_to_acc_i, addr_i, wdata_i, imm_i} = {w, r, al, al, al, a, d, d};
		{skip_nonzero_i, skip_zero_i, sleep_i, kick_second_half_i, kick_first_half_i, kick_single_i} = ev;
		alu_op_i = op;
		exec_i = 1'b1;
		@(negedge mclk_i);
		{exec_i, wr_i, rd_i, alu_en_i, skip_nonzero_i, skip_zero_i, sleep_i} = '0;
		{kick_second_half_i, kick_first_half_i, kick_single_i} = '0;
	endtask : run

	// Count falling edges until a chip reset pulse, at most lim
	task automatic wait_rst(input int lim, output int cnt);
		cnt = 0;
		while (cnt < lim && chip_rst_o !== 1'b1) begin
			@(negedge mclk_i);
			cnt++;
		end
	endtask : wait_rst

	task automatic summarize();
		if (num_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{exec_i, rd_i, wr_i, use_imm_i, alu_en_i, alu_to_acc_i, skip_zero_i, skip_nonzero_i} = '0;
		{kick_single_i, kick_first_half_i, kick_second_half_i, sleep_i, wake_event_i} = '0;
		{addr_i, rd_ptr, wdata_i, imm_i} = '0;
		alu_op_i = ALU_PASS;
		repeat (4) @(negedge mclk_i);
		rst_n_i = 1'b1;
		`CHK("flags_rst", 8'h00, flags_o)
		foreach (rows[i]) begin
			run(1, 0, `ASW_ADR_WORKING, rows[i].acc, 0, ALU_PASS, 6'h00);
			run(1, 0, `ASW_ADR_FLAGS, {7'h00, rows[i].cin}, 0, ALU_PASS, 6'h00);
			run(0, 0, 6'h00, rows[i].imm, 1, rows[i].op, 6'h00);
			`CHK("alu_res", rows[i].res, acc_o)
			`CHK("alu_flags", rows[i].fl, flags_o[3:0] & rows[i].mk)
		end
		// Skip tests on zero and non-zero results
		run(0, 0, 6'h00, 8'h00, 1, ALU_PASS, 6'h10);
		`CHK("skip_z", 1'b1, skip_o)
		run(0, 0, 6'h00, 8'h01, 1, ALU_PASS, 6'h10);
		`CHK("skip_z1", 1'b0, skip_o)
		run(0, 0, 6'h00, 8'h01, 1, ALU_PASS, 6'h20);
		`CHK("skip_nz", 1'b1, skip_o)
		// Pointer keeps six bits and reads ones above them
		run(1, 0, `ASW_ADR_POINTER, 8'h95, 0, ALU_PASS, 6'h00);
		run(0, 1, `ASW_ADR_POINTER, 8'h00, 0, ALU_PASS, 6'h00);
		`CHK("ptr", 8'hD5, rdata_o)
		// Indirect store and load through the pointer
		rd_ptr = 6'h25;
		run(1, 0, `ASW_ADR_POINTER, 8'h25, 0, ALU_PASS, 6'h00);
		run(1, 0, `ASW_ADR_INDIRECT, 8'h5A, 0, ALU_PASS, 6'h00);
		run(0, 1, `ASW_ADR_INDIRECT, 8'h00, 0, ALU_PASS, 6'h00);
		`CHK("ind_mem", 8'h5A, u_mem.mem[6'h25])
		`CHK("ind_rd", 8'h5A, rdata_o)
		// Pointer at the indirect slot itself: reads zero, stores nothing
		rd_ptr = 6'h00;
		run(1, 0, `ASW_ADR_POINTER, 8'h00, 0, ALU_PASS, 6'h00);
		wn = u_mem.writes;
		run(1, 0, `ASW_ADR_INDIRECT, 8'h77, 0, ALU_PASS, 6'h00);
		run(0, 1, `ASW_ADR_INDIRECT, 8'h00, 0, ALU_PASS, 6'h00);
		`CHK("self_rd", 8'h00, rdata_o)
		`CHK("self_wr", wn, u_mem.writes)
		run(1, 0, `ASW_ADR_WORKING, 8'h3C, 0, ALU_PASS, 6'h00);
		run(0, 1, `ASW_ADR_WORKING, 8'h00, 0, ALU_PASS, 6'h00);
		`CHK("acc_rd", 8'h3C, rdata_o)
		run(1, 0, `ASW_ADR_FLAGS, 8'hFF, 0, ALU_PASS, 6'h00);
		`CHK("flags_wr", 8'h0F, flags_o)
		// Divider on the instruction clock: 2^8 ticks of four system clocks
		opt_wdt_en_i = 1'b1;
		run(0, 0, 6'h00, 8'h00, 0, ALU_PASS, 6'h01);
		wait_rst(1200, n);
		`CHK("wdt_time", 1'b1, n >= 1000 && n <= 1100)
		@(negedge mclk_i);
		`CHK("to_set", 1'b1, flags_o[`ASW_BIT_TO])
		// Sleep stops everything until the wake event
		run(1, 0, `ASW_ADR_WORKING, 8'h66, 0, ALU_PASS, 6'h00);
		run(0, 0, 6'h00, 8'h00, 0, ALU_PASS, 6'h08);
		`CHK("halted", 1'b1, halted_o)
		`CHK("pdf_to", 2'b01, flags_o[5:4])
		run(1, 0, `ASW_ADR_WORKING, 8'h11, 0, ALU_PASS, 6'h00);
		wait_rst(1200, n);
		`CHK("halt_wdt", 1200, n)
		`CHK("halt_acc", 8'h66, acc_o)
		wake_event_i = 1'b1;
		n = 0;
		while (halted_o !== 1'b0 && n < 50) begin
			@(negedge mclk_i);
			n++;
		end
		`CHK("wake", 1'b1, wake_o)
		wake_event_i = 1'b0;
		if (n == 50) begin
			num_errors++;
			summarize();
		end
		run(0, 0, 6'h00, 8'h00, 0, ALU_PASS, 6'h01);
		`CHK("kick_flags", 2'b00, flags_o[5:4])
		// Dual mode: both halves clear, a lone half does not
		opt_dual_kick_i = 1'b1;
		run(0, 0, 6'h00, 8'h00, 0, ALU_PASS, 6'h02);
		run(0, 0, 6'h00, 8'h00, 0, ALU_PASS, 6'h04);
		repeat (600) @(negedge mclk_i);
		run(0, 0, 6'h00, 8'h00, 0, ALU_PASS, 6'h02);
		run(0, 0, 6'h00, 8'h00, 0, ALU_PASS, 6'h02);
		wait_rst(700, n);
		`CHK("dual_half", 1'b1, n >= 350 && n <= 500)
		// Clear pin low gives a chip reset at once
		@(negedge mclk_i);
		ext_clear_pin_n_i = 1'b0;
		@(negedge mclk_i);
		`CHK("pin_rst", 1'b1, chip_rst_o)
		ext_clear_pin_n_i = 1'b1;
		// Disabled watchdog: kick is a no-op and no timeout comes
		{opt_wdt_en_i, opt_dual_kick_i} = 2'b00;
		run(0, 0, 6'h00, 8'h00, 0, ALU_PASS, 6'h01);
		`CHK("off_kick", 2'b10, flags_o[5:4])
		wait_rst(1500, n);
		`CHK("off_wdt", 1500, n)
		// Quarter-rate clock flips every two system clocks
		q = clk_qtr_o;
		repeat (2) @(negedge mclk_i);
		`CHK("clk_qtr", ~q, clk_qtr_o)
		// Crystal mode keeps the pin low
		opt_rc_osc_i = 1'b0;
		repeat (2) @(negedge mclk_i);
		`CHK("clk_qtr_off", 1'b0, clk_qtr_o)
		summarize();
	end
endmodule : testbench
